//--- srac_checker.sv
`timescale 1ns/1ns
`default_nettype none
module srac_checker #(
  parameter int POWER_WAIT_CYCLES = 8
) (
  input wire logic                        clk_sys_in,
  input wire logic                        nrst_in,
  input wire logic                        req_valid_in,
  input wire srac_pkg::srac_req_t         req_in,
  input wire logic                        req_ready_out,
  input wire logic                        rsp_valid_out,
  input wire srac_pkg::srac_pins_t        pins_out,
  input wire logic [srac_pkg::DATA_W-1:0] data_pin_out,
  input wire logic                        data_pin_oe_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  logic [31:0] up_reg;
  logic [31:0] up_next;
  logic        rd;
  logic        wr;
  assign rd = req_valid_in && req_ready_out && !req_in.write;
  assign wr = req_valid_in && req_ready_out && req_in.write;
  always_comb up_next = (up_reg == 32'hFFFFFFFF) ? up_reg : up_reg + 32'h1;
  always_ff @(posedge clk_sys_in or negedge nrst_in)
    if (!nrst_in)
      up_reg <= 32'h0;
    else
      up_reg <= up_next;
  AST_PWR: assert property (req_ready_out |-> up_reg >= POWER_WAIT_CYCLES)
    else $error("ready too early");
  AST_CLASH: assert property (data_pin_oe_out |-> pins_out.out_drive_n)
    else $error("data driven with output drive on");
  AST_STB: assert property (!pins_out.strobe_n |-> !pins_out.select_active_low &&
    pins_out.select_active_high && !(pins_out.low_byte_lane_n && pins_out.high_byte_lane_n))
    else $error("strobe without select or lane");
  AST_HOLD: assert property ($fell(pins_out.strobe_n) |-> data_pin_oe_out
    ##1 (pins_out.strobe_n && data_pin_oe_out && $stable(data_pin_out))) else $error("data hold");
  AST_ADDR: assert property (!pins_out.strobe_n |-> $stable(pins_out.addr) ##1 $stable(pins_out.addr))
    else $error("address moved");
  AST_RD_PINS: assert property (rd |=> !pins_out.out_drive_n && pins_out.strobe_n &&
    {pins_out.high_byte_lane_n, pins_out.low_byte_lane_n} == $past(req_in.lanes_n)) else $error("read pins");
  AST_RD_LAT: assert property (rd |=> !rsp_valid_out [*3] ##1 rsp_valid_out)
    else $error("read latency");
  AST_WR_SEQ: assert property (wr |-> ##2 !pins_out.strobe_n ##1 pins_out.strobe_n ##2 req_ready_out)
    else $error("write sequence");
  AST_ADDR_REQ: assert property (rd || wr |=> pins_out.addr == $past(req_in.addr))
    else $error("wrong address");
  cover property (rd);
  cover property (wr);
  cover property (rsp_valid_out);
endmodule
bind srac_ctrl srac_checker #(.POWER_WAIT_CYCLES(POWER_WAIT_CYCLES)) chk_u (.clk_sys_in, .nrst_in,
  .req_valid_in, .req_in, .req_ready_out, .rsp_valid_out, .pins_out, .data_pin_out, .data_pin_oe_out);
`default_nettype wire

//--- srac_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Host-side controller for an asynchronous 1M x 16 static memory.
module srac_ctrl #(
  parameter int POWER_WAIT_CYCLES = srac_pkg::POWER_WAIT_CYC
) (
  input  wire logic                        clk_sys_in,
  input  wire logic                        nrst_in,
  input  wire logic                        req_valid_in,
  input  wire srac_pkg::srac_req_t         req_in,
  output var  logic                        req_ready_out,
  output var  logic                        rsp_valid_out,
  output var  logic [srac_pkg::DATA_W-1:0] rsp_data_out,
  output var  srac_pkg::srac_pins_t        pins_out,
  output var  logic [srac_pkg::DATA_W-1:0] data_pin_out,
  output var  logic                        data_pin_oe_out,
  input  wire logic [srac_pkg::DATA_W-1:0] data_pin_in
);

  // Idle pattern: memory deselected, output drive and strobe high, both lanes off.
  localparam srac_pkg::srac_pins_t IDLE_PINS = '{select_active_low: 1'b1, select_active_high: 1'b0,
                                                 out_drive_n: 1'b1, strobe_n: 1'b1,
                                                 low_byte_lane_n: 1'b1, high_byte_lane_n: 1'b1,
                                                 addr: '0};

  logic                        powered;
  srac_pkg::srac_state_t       state_reg;
  srac_pkg::srac_state_t       state_next;
  logic [3:0]                  cnt_reg;
  logic [3:0]                  cnt_next;
  srac_pkg::srac_pins_t        pins_reg;
  srac_pkg::srac_pins_t        pins_next;
  logic [srac_pkg::DATA_W-1:0] wdata_reg;
  logic [srac_pkg::DATA_W-1:0] wdata_next;
  logic                        oe_reg;
  logic                        oe_next;
  logic                        ready_reg;
  logic                        ready_next;
  logic                        rvalid_reg;
  logic                        rvalid_next;
  logic [srac_pkg::DATA_W-1:0] rdata_reg;
  logic [srac_pkg::DATA_W-1:0] rdata_next;
  // Two flops bring the data pins into the clock domain before anything reads them.
  logic [srac_pkg::DATA_W-1:0] din_meta_reg;
  logic [srac_pkg::DATA_W-1:0] din_sync_reg;

  // Parks the memory deselected with all strobes and lanes high. The address is kept so that it
  // never moves on the same edge as the select or strobe that ends an access.
  function automatic srac_pkg::srac_pins_t park_pins(input logic [srac_pkg::ADDR_W-1:0] addr);
    srac_pkg::srac_pins_t parked;
    parked      = IDLE_PINS;
    parked.addr = addr;
    return parked;
  endfunction

  // Steps a dwell counter down by one; it rests at zero instead of wrapping round.
  function automatic logic [3:0] step_down(input logic [3:0] cnt);
    logic [3:0] res;
    res = cnt;
    if (cnt != 4'h0)
    begin
      res = cnt - 4'h1;
    end
    return res;
  endfunction

  // Holds the controller off the memory until the supply has settled after reset.
  srac_wait #(
    .CYCLES(POWER_WAIT_CYCLES)
  ) u_wait (
    .clk_sys_in(clk_sys_in),
    .nrst_in   (nrst_in),
    .done_out  (powered)
  );

  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    pins_next   = pins_reg;
    wdata_next  = wdata_reg;
    oe_next     = oe_reg;
    ready_next  = 1'b0;
    rvalid_next = 1'b0;
    rdata_next  = rdata_reg;
    case (state_reg)
      srac_pkg::ST_POWER:
      begin
        if (powered)
        begin
          state_next = srac_pkg::ST_IDLE;
          ready_next = 1'b1;
        end
      end
      srac_pkg::ST_IDLE:
      begin
        ready_next = 1'b1;
        if (req_valid_in && ready_reg)
        begin
          ready_next                   = 1'b0;
          pins_next.addr               = req_in.addr;
          pins_next.select_active_low  = 1'b0;
          pins_next.select_active_high = 1'b1;
          pins_next.low_byte_lane_n    = req_in.lanes_n[0];
          pins_next.high_byte_lane_n   = req_in.lanes_n[1];
          if (req_in.write)
          begin
            // Output drive stays high so the memory never drives the bus while we do.
            pins_next.out_drive_n = 1'b1;
            wdata_next            = req_in.wdata;
            state_next            = srac_pkg::ST_WSETUP;
          end
          else
          begin
            pins_next.out_drive_n = 1'b0;
            cnt_next              = srac_pkg::READ_CYC;
            state_next            = srac_pkg::ST_READ;
          end
        end
      end
      srac_pkg::ST_READ:
      begin
        // Synchroniser adds two cycles of latency before the sample is used.
        if (cnt_reg == 4'h0)
        begin
          rdata_next  = din_sync_reg;
          rvalid_next = 1'b1;
          pins_next   = park_pins(pins_reg.addr);
          cnt_next    = srac_pkg::FLOAT_CYC;
          state_next  = srac_pkg::ST_RECOVER;
        end
        else
        begin
          cnt_next = step_down(cnt_reg);
        end
      end
      srac_pkg::ST_WSETUP:
      begin
        pins_next.strobe_n = 1'b0;
        oe_next            = 1'b1;
        cnt_next           = srac_pkg::STROBE_CYC;
        state_next         = srac_pkg::ST_WSTROBE;
      end
      srac_pkg::ST_WSTROBE:
      begin
        if (cnt_reg == 4'h1)
        begin
          // Only the strobe ends the write; address and data are held past it.
          pins_next.strobe_n = 1'b1;
          state_next         = srac_pkg::ST_WEND;
        end
        else
        begin
          cnt_next = step_down(cnt_reg);
        end
      end
      srac_pkg::ST_WEND:
      begin
        // Selects and lanes release one cycle after the strobe; address unchanged.
        pins_next      = park_pins(pins_reg.addr);
        oe_next        = 1'b0;
        cnt_next       = srac_pkg::FLOAT_CYC;
        state_next     = srac_pkg::ST_RECOVER;
      end
      srac_pkg::ST_RECOVER:
      begin
        if (cnt_reg <= 4'h1)
        begin
          ready_next = 1'b1;
          state_next = srac_pkg::ST_IDLE;
        end
        else
        begin
          cnt_next = step_down(cnt_reg);
        end
      end
      default:
      begin
        pins_next  = IDLE_PINS;
        oe_next    = 1'b0;
        state_next = srac_pkg::ST_POWER;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_reg    <= srac_pkg::ST_POWER;
      cnt_reg      <= 4'h0;
      pins_reg     <= IDLE_PINS;
      wdata_reg    <= '0;
      oe_reg       <= 1'b0;
      ready_reg    <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= '0;
      din_meta_reg <= '0;
      din_sync_reg <= '0;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      pins_reg     <= pins_next;
      wdata_reg    <= wdata_next;
      oe_reg       <= oe_next;
      ready_reg    <= ready_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      din_meta_reg <= data_pin_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  assign pins_out        = pins_reg;
  assign data_pin_out    = wdata_reg;
  assign data_pin_oe_out = oe_reg;
  assign req_ready_out   = ready_reg;
  assign rsp_valid_out   = rvalid_reg;
  assign rsp_data_out    = rdata_reg;

endmodule
`default_nettype wire

//--- srac_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module srac_ctrl_tb;
  localparam int PW = 8;
  logic                 clk_sys_in = 1'b0;
  logic                 nrst_in = 1'b0;
  logic                 req_valid_in = 1'b0;
  srac_pkg::srac_req_t  req_in = '0;
  srac_pkg::srac_pins_t pins;
  logic                 rdy, rv, oe;
  logic [15:0]          rdata, dpo, mq, bus;
  logic [7:0]           ctl;
  int                   n_fail = 0;
  int                   total_checks = 0;
  int                   cyc = 0;
  assign bus = oe ? dpo : mq;
  assign ctl = {pins.select_active_low, pins.select_active_high, pins.out_drive_n, pins.strobe_n,
    pins.low_byte_lane_n, pins.high_byte_lane_n, oe, rdy};
  srac_ctrl #(.POWER_WAIT_CYCLES(PW)) dut_u (.clk_sys_in, .nrst_in, .req_valid_in, .req_in,
    .req_ready_out(rdy), .rsp_valid_out(rv), .rsp_data_out(rdata), .pins_out(pins),
    .data_pin_out(dpo), .data_pin_oe_out(oe), .data_pin_in(bus));
  srac_mem mem_u (.clk_sys_in, .pins_in(pins), .data_in(bus), .data_out(mq));
  initial forever #20 clk_sys_in = ~clk_sys_in;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      final_report();
    end
  end
  task automatic req(input logic w, input logic [1:0] ln, input logic [19:0] a, input logic [15:0] d);
    req_valid_in <= 1'b1;
    req_in <= {w, ln, a, d};
    do @(posedge clk_sys_in); while (rdy !== 1'b1);
    req_valid_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [1:0] ln, input logic [19:0] a, input logic [15:0] e);
    logic [15:0] m;
    m = {{8{!ln[1]}}, {8{!ln[0]}}};
    req(1'b0, ln, a, 16'h0);
    do @(posedge clk_sys_in); while (rv !== 1'b1);
    check(rdata & m, e & m);
  endtask
  task automatic t_reset();
    int n;
    n = 0;
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    check({8'h0, ctl}, 16'h00BC);
    nrst_in <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end while (rdy !== 1'b1);
    check({15'h0, n > PW}, 16'h0001);
  endtask
  task automatic t_ends();
    req(1'b1, 2'b00, 20'hFFFFF, 16'hA5C3);
    req(1'b1, 2'b00, 20'h00000, 16'h1234);
    rd(2'b00, 20'hFFFFF, 16'hA5C3);
    rd(2'b00, 20'h00000, 16'h1234);
  endtask
  task automatic t_lanes();
    req(1'b1, 2'b00, 20'h00100, 16'h1111);
    req(1'b1, 2'b10, 20'h00100, 16'hAAAA);
    req(1'b1, 2'b01, 20'h00100, 16'hBBBB);
    rd(2'b10, 20'h00100, 16'h00AA);
    rd(2'b01, 20'h00100, 16'hBB00);
    rd(2'b00, 20'h00100, 16'hBBAA);
  endtask
  task automatic t_midreset();
    req(1'b1, 2'b00, 20'h00200, 16'h5555);
    t_reset();
    rd(2'b00, 20'h00100, 16'hBBAA);
  endtask
  initial
  begin
    t_reset();
    t_ends();
    t_lanes();
    t_midreset();
    final_report();
  end
endmodule
`default_nettype wire

//--- srac_mem.sv
`timescale 1ns/1ns
`default_nettype none
// Acting on the falling edge stands in for the memory's short asynchronous access: pins that the
// controller sets after a rising edge are answered before the next rising edge samples the bus.
module srac_mem (
  input  wire logic                        clk_sys_in,
  input  wire srac_pkg::srac_pins_t        pins_in,
  input  wire logic [srac_pkg::DATA_W-1:0] data_in,
  output var  logic [srac_pkg::DATA_W-1:0] data_out
);
  logic [15:0] mem [logic [srac_pkg::ADDR_W-1:0]];
  logic [15:0] w;
  logic [1:0]  lane;
  logic        sel;
  logic        rd;
  assign sel = !pins_in.select_active_low && pins_in.select_active_high;
  assign lane = {pins_in.high_byte_lane_n, pins_in.low_byte_lane_n};
  assign rd = sel && !pins_in.out_drive_n && pins_in.strobe_n;
  initial data_out = 16'h0;
  always @(negedge clk_sys_in)
  begin
    w = mem.exists(pins_in.addr) ? mem[pins_in.addr] : 16'h0;
    if (sel && !pins_in.strobe_n)
    begin
      if (!lane[0]) w[7:0] = data_in[7:0];
      if (!lane[1]) w[15:8] = data_in[15:8];
      mem[pins_in.addr] = w;
    end
    // A lane that is not driven shows a level that changes every cycle.
    for (int i = 0; i < 2; i++)
      data_out[i*8+:8] <= (rd && !lane[i]) ? w[i*8+:8] : ~data_out[i*8+:8];
  end
endmodule
`default_nettype wire

//--- srac_pkg.sv
// What this block does
// - A write needs active selects, strobe and lane enables; releasing any ends it.
// - Data setup and hold are timed against the edge that ends the write.
// - Strobe pulse and write cycle last at least data setup plus strobe-to-float time.
// - Controller never drives data while the memory may still be driving.
// - Controller waits at least 1 ms after power before the first access.
package srac_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int POWER_WAIT_MS = 1;
  localparam int POWER_WAIT_CYC = (POWER_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_SETUP_TIME_PS = 5500;
  localparam int STROBE_TO_FLOAT_TIME_NS = 5;
  localparam int STROBE_MIN_NS = 7;
  localparam int ACCESS_NS = 10;
  localparam int FLOAT_NS = 5;
  localparam int STROBE_SUM_NS = (DATA_SETUP_TIME_PS + 999) / 1000 + STROBE_TO_FLOAT_TIME_NS;
  localparam int STROBE_NS = (STROBE_SUM_NS > STROBE_MIN_NS) ? STROBE_SUM_NS : STROBE_MIN_NS;
  localparam int STROBE_CYC_I = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_CYC = 4'(STROBE_CYC_I < 1 ? 1 : STROBE_CYC_I);
  localparam int READ_CYC_I = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam logic [3:0] READ_CYC = 4'(READ_CYC_I);
  localparam int FLOAT_CYC_I = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] FLOAT_CYC = 4'(FLOAT_CYC_I < 1 ? 1 : FLOAT_CYC_I);

  typedef struct packed {
    logic              write;
    logic [1:0]        lanes_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srac_req_t;

  typedef struct packed {
    logic              select_active_low;
    logic              select_active_high;
    logic              out_drive_n;
    logic              strobe_n;
    logic              low_byte_lane_n;
    logic              high_byte_lane_n;
    logic [ADDR_W-1:0] addr;
  } srac_pins_t;

  typedef enum logic [2:0] {
    ST_POWER,
    ST_IDLE,
    ST_READ,
    ST_WSETUP,
    ST_WSTROBE,
    ST_WEND,
    ST_RECOVER
  } srac_state_t;

endpackage

//--- srac_wait.sv
`timescale 1ns/1ns
`default_nettype none
// Counts cycles after reset and raises done once the count has elapsed.
module srac_wait #(
  parameter int CYCLES = 25000
) (
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  output var  logic done_out
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          done_reg;
  logic          done_next;

  always_comb
  begin
    cnt_next  = cnt_reg;
    done_next = done_reg;
    if (cnt_reg != LAST)
    begin
      cnt_next = cnt_reg + CW'(1);
    end
    else
    begin
      done_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done_out = done_reg;

endmodule
`default_nettype wire
